// *** inc/i2cbc_pkg.sv ***
/*
 * Package for the bus-collision-aware condition generator of the two-wire master:
 * register offsets, field positions, reset values, states and carrier structs.
 * Assumes a 32-bit Avalon-MM slave port with byte addressing, one register per word.
 */
// Overview of operation
// - start request flags collision if data or clock already low at start
// - start collision aborts start, sets collision flag, module returns idle
// - start releases lines; data high loads counter; clock low then is collision
// - data low during first start count resets counter and drives data low now
// - data high at count end: drive data low, recount ignoring clock, then clock low
// - restart: data low when clock rises is a collision
// - restart releases data, counts, releases clock, samples data once clock high
// - restart: data high reloads counter; later data fall is no collision
// - restart: clock falling before expiry while data undriven is collision
// - restart expiry with both high: drive data low, recount, then clock low
// - stop holds data low, releases clock, counts once clock high, releases data, recounts, then samples data
// - stop: data still low after final count is collision
// - stop: clock low once seen high after release, until the final count ends, is collision
// - any collision releases both lines and clears sequence request bits
// - after collision keep watching; stop seen on bus sets event flag
`default_nettype none
package i2cbc_pkg;
   localparam logic [7:0] REG_SEQ_CTRL   = 8'h00; // sequence_control_reg
   localparam logic [7:0] REG_BAUD       = 8'h04; // baud_reload_value
   localparam logic [7:0] REG_IRQ_FLAGS  = 8'h08; // peripheral_irq_flags
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h0C; // peripheral_irq_enable
   localparam logic [7:0] REG_STATUS     = 8'h10; // live line and state view
   localparam int SEQ_START_BIT   = 0;
   localparam int SEQ_RESTART_BIT = 1;
   localparam int SEQ_STOP_BIT    = 2;
   localparam int FLG_EVENT_BIT   = 3;
   localparam int FLG_COLL_BIT    = 5;
   localparam logic [7:0] BAUD_RESET  = 8'h13;
   localparam logic [7:0] FLAGS_MASK  = 8'h28;
   localparam logic [31:0] READ_ZERO  = 32'h00000000;

   typedef enum logic [3:0] {
      ST_IDLE, ST_S_WAIT, ST_S_CNT1, ST_S_CNT2,
      ST_R_CNT1, ST_R_SCLWAIT, ST_R_CNT2, ST_R_CNT3,
      ST_P_SDAWAIT, ST_P_SCLWAIT, ST_P_CNT1, ST_P_CNT2
   } i2cbc_state_e;

   typedef struct packed {
      logic sda;
      logic scl;
   } i2cbc_lines_s;
endpackage
`default_nettype wire

// *** logic/i2cbc_core.sv ***
/*
 * Start / repeated start / stop generator with bus collision detection,
 * Avalon-MM register slave and a level interrupt.
 * Assumes open-drain bus pins resolved outside; pin inputs are asynchronous.
 */
`default_nettype none
module i2cbc_core
   import i2cbc_pkg::*;
(
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // two-wire bus pins
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   // interrupt
   output logic             irq
);
   i2cbc_lines_s   meta_q, line_q, prev_q;
   i2cbc_state_e   state_q;
   logic [7:0]     cnt_q, baud_q, flags_q, ien_q;
   logic [2:0]     seq_q;
   logic           sda_drv_q, scl_drv_q, ack_q;
   logic           coll_ev, stop_ev, done_ev, expired;

   // two-stage synchroniser; first stage read only by the second
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         meta_q <= '{sda: 1'b1, scl: 1'b1};
         line_q <= '{sda: 1'b1, scl: 1'b1};
         prev_q <= '{sda: 1'b1, scl: 1'b1};
      end
      else if (clk_en)
      begin
         meta_q <= '{sda: sda_in, scl: scl_in};
         line_q <= meta_q;
         prev_q <= line_q;
      end

   assign expired = (cnt_q == 8'h00);
   // stop on bus: data rises while clock high
   assign stop_ev = line_q.scl && prev_q.scl && line_q.sda && !prev_q.sda;

   always_comb
   begin
      coll_ev = 1'b0;
      done_ev = 1'b0;
      unique case (state_q)
         ST_S_WAIT:    coll_ev = !line_q.sda || !line_q.scl;
         ST_S_CNT1:    coll_ev = line_q.sda && !line_q.scl;
         ST_S_CNT2:    done_ev = expired;
         ST_R_SCLWAIT: coll_ev = line_q.scl && !line_q.sda;
         ST_R_CNT2:    coll_ev = prev_q.scl && !line_q.scl && !sda_drv_q;
         ST_R_CNT3:    done_ev = expired;
         ST_P_SCLWAIT: coll_ev = 1'b0;
         ST_P_CNT1:    coll_ev = !line_q.scl;
         ST_P_CNT2:    coll_ev = !line_q.scl || (expired && !line_q.sda);
         default:      coll_ev = 1'b0;
      endcase
      if (state_q == ST_P_CNT2 && expired && line_q.sda && line_q.scl)
         done_ev = 1'b1;
   end

   // condition sequencer
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         state_q   <= ST_IDLE;
         cnt_q     <= 8'h00;
         sda_drv_q <= 1'b0;
         scl_drv_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
         if (coll_ev)
         begin
            state_q   <= ST_IDLE;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
         end
         else
            unique case (state_q)
               ST_IDLE:
                  if (seq_q[SEQ_START_BIT])
                  begin
                     sda_drv_q <= 1'b0;
                     scl_drv_q <= 1'b0;
                     state_q   <= ST_S_WAIT;
                  end
                  else if (seq_q[SEQ_RESTART_BIT])
                  begin
                     sda_drv_q <= 1'b0;
                     cnt_q     <= baud_q;
                     state_q   <= ST_R_CNT1;
                  end
                  else if (seq_q[SEQ_STOP_BIT])
                  begin
                     sda_drv_q <= 1'b1;
                     state_q   <= ST_P_SDAWAIT;
                  end
               ST_S_WAIT:
               begin
                  cnt_q   <= baud_q;
                  state_q <= ST_S_CNT1;
               end
               ST_S_CNT1:
                  if (!line_q.sda)
                  begin
                     cnt_q     <= baud_q;
                     sda_drv_q <= 1'b1;
                     state_q   <= ST_S_CNT2;
                  end
                  else if (expired)
                  begin
                     sda_drv_q <= 1'b1;
                     cnt_q     <= baud_q;
                     state_q   <= ST_S_CNT2;
                  end
               ST_S_CNT2:
                  if (expired)
                  begin
                     scl_drv_q <= 1'b1;
                     state_q   <= ST_IDLE;
                  end
               ST_R_CNT1:
                  if (expired)
                  begin
                     scl_drv_q <= 1'b0;
                     state_q   <= ST_R_SCLWAIT;
                  end
               ST_R_SCLWAIT:
                  if (line_q.scl)
                  begin
                     cnt_q   <= baud_q;
                     state_q <= ST_R_CNT2;
                  end
               ST_R_CNT2:
                  if (!line_q.sda && !sda_drv_q)
                  begin
                     sda_drv_q <= 1'b1;
                     cnt_q     <= baud_q;
                     state_q   <= ST_R_CNT3;
                  end
                  else if (expired)
                  begin
                     sda_drv_q <= 1'b1;
                     cnt_q     <= baud_q;
                     state_q   <= ST_R_CNT3;
                  end
               ST_R_CNT3:
                  if (expired)
                  begin
                     scl_drv_q <= 1'b1;
                     state_q   <= ST_IDLE;
                  end
               ST_P_SDAWAIT:
                  if (!line_q.sda)
                  begin
                     scl_drv_q <= 1'b0;
                     state_q   <= ST_P_SCLWAIT;
                  end
               ST_P_SCLWAIT:
                  if (line_q.scl)
                  begin
                     cnt_q   <= baud_q;
                     state_q <= ST_P_CNT1;
                  end
               ST_P_CNT1:
                  if (expired)
                  begin
                     sda_drv_q <= 1'b0;
                     cnt_q     <= baud_q;
                     state_q   <= ST_P_CNT2;
                  end
               ST_P_CNT2:
                  if (expired)
                     state_q <= ST_IDLE;
               default:
                  state_q <= ST_IDLE;
            endcase
      end

   // pins: only low is ever driven
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         sda_oe  <= 1'b0;
         scl_oe  <= 1'b0;
      end
      else if (clk_en)
      begin
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         sda_oe  <= sda_drv_q && !coll_ev;
         scl_oe  <= scl_drv_q && !coll_ev;
      end

   // sequence request bits, cleared on completion or collision
   always_ff @(posedge clk or posedge reset)
      if (reset)
         seq_q <= 3'h0;
      else if (clk_en)
      begin
         if (coll_ev || done_ev)
            seq_q <= 3'h0;
         else if (avs_write && !ack_q && avs_address == REG_SEQ_CTRL && avs_byteenable[0]
                  && state_q == ST_IDLE)
            seq_q <= avs_writedata[2:0];
      end

   // sticky flags: hardware set beats write-one-to-clear
   always_ff @(posedge clk or posedge reset)
      if (reset)
         flags_q <= 8'h00;
      else if (clk_en)
      begin
         for (int i = 0; i < 8; i++)
         begin
            if ((i == FLG_COLL_BIT && coll_ev)
                || (i == FLG_EVENT_BIT && (done_ev || stop_ev)))
               flags_q[i] <= 1'b1;
            else if (avs_write && !ack_q && avs_address == REG_IRQ_FLAGS && avs_byteenable[0]
                     && avs_writedata[i])
               flags_q[i] <= 1'b0;
         end
      end

   // software registers and bus answer; one wait cycle per access
   always_ff @(posedge clk or posedge reset)
      if (reset)
      begin
         baud_q          <= BAUD_RESET;
         ien_q           <= 8'h00;
         ack_q           <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= READ_ZERO;
      end
      else if (clk_en)
      begin
         ack_q           <= (avs_read || avs_write) && !ack_q;
         avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
         if (avs_write && !ack_q && avs_byteenable[0])
            unique case (avs_address)
               REG_BAUD:       baud_q <= avs_writedata[7:0];
               REG_IRQ_ENABLE: ien_q  <= avs_writedata[7:0] & FLAGS_MASK;
               default:        ;
            endcase
         if (avs_read && !ack_q)
            unique case (avs_address)
               REG_SEQ_CTRL:   avs_readdata <= {29'h0, seq_q};
               REG_BAUD:       avs_readdata <= {24'h0, baud_q};
               REG_IRQ_FLAGS:  avs_readdata <= {24'h0, flags_q};
               REG_IRQ_ENABLE: avs_readdata <= {24'h0, ien_q};
               REG_STATUS:     avs_readdata <= {22'h0, line_q.scl, line_q.sda, 4'h0, state_q};
               default:        avs_readdata <= READ_ZERO;
            endcase
      end

   always_ff @(posedge clk or posedge reset)
      if (reset)
         irq <= 1'b0;
      else if (clk_en)
         irq <= |(flags_q & ien_q);

   // assertions
   property p_start_coll;
      @(posedge clk) disable iff (reset)
      clk_en && state_q == ST_S_WAIT && !line_q.scl |=> flags_q[FLG_COLL_BIT] && state_q == ST_IDLE;
   endproperty
   a_start_coll: assert property (p_start_coll) else $error("start collision missed");

   property p_coll_release;
      @(posedge clk) disable iff (reset)
      clk_en && coll_ev |=> !sda_oe && !scl_oe && seq_q == 3'h0;
   endproperty
   a_coll_release: assert property (p_coll_release) else $error("lines not released");

   property p_early_sda;
      @(posedge clk) disable iff (reset)
      clk_en && state_q == ST_S_CNT1 && !line_q.sda |=> sda_drv_q && cnt_q == baud_q;
   endproperty
   a_early_sda: assert property (p_early_sda) else $error("early data drive missed");

   property p_start_done;
      @(posedge clk) disable iff (reset)
      clk_en && state_q == ST_S_CNT2 && expired |=> scl_drv_q ##1 scl_oe;
   endproperty
   a_start_done: assert property (p_start_done) else $error("clock not driven low");

   property p_rs_coll;
      @(posedge clk) disable iff (reset)
      clk_en && state_q == ST_R_SCLWAIT && line_q.scl && !line_q.sda |=> flags_q[FLG_COLL_BIT];
   endproperty
   a_rs_coll: assert property (p_rs_coll) else $error("restart data-low collision missed");

   property p_rs_clk_fall;
      @(posedge clk) disable iff (reset)
      clk_en && state_q == ST_R_CNT2 && $fell(line_q.scl) && !sda_drv_q |=> state_q == ST_IDLE;
   endproperty
   a_rs_clk_fall: assert property (p_rs_clk_fall) else $error("restart clock-fall collision missed");

   property p_stop_coll;
      @(posedge clk) disable iff (reset)
      clk_en && state_q == ST_P_CNT2 && expired && !line_q.sda |=> flags_q[FLG_COLL_BIT];
   endproperty
   a_stop_coll: assert property (p_stop_coll) else $error("stop collision missed");

   property p_irq;
      @(posedge clk) disable iff (reset)
      clk_en && !(flags_q[FLG_COLL_BIT] && ien_q[FLG_COLL_BIT]) && !(flags_q[FLG_EVENT_BIT] && ien_q[FLG_EVENT_BIT])
      |=> !irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without enabled flag");

   property p_start_clk_low;
      @(posedge clk) disable iff (reset)
      clk_en && state_q == ST_S_CNT1 && line_q.sda && !line_q.scl |=> flags_q[FLG_COLL_BIT] && state_q == ST_IDLE;
   endproperty
   a_start_clk_low: assert property (p_start_clk_low) else $error("start clock-low collision missed");

   property p_rs_done;
      @(posedge clk) disable iff (reset)
      clk_en && state_q == ST_R_CNT3 && expired |=> scl_drv_q && state_q == ST_IDLE && seq_q == 3'h0;
   endproperty
   a_rs_done: assert property (p_rs_done) else $error("restart did not end with clock low");

   property p_stop_clk_low;
      @(posedge clk) disable iff (reset)
      clk_en && state_q == ST_P_CNT1 && !line_q.scl |=> flags_q[FLG_COLL_BIT] && !scl_oe && !sda_oe;
   endproperty
   a_stop_clk_low: assert property (p_stop_clk_low) else $error("stop clock-low collision missed");

   property p_bus_stop;
      @(posedge clk) disable iff (reset)
      clk_en && stop_ev |=> flags_q[FLG_EVENT_BIT];
   endproperty
   a_bus_stop: assert property (p_bus_stop) else $error("stop on bus not flagged");

   // frozen block must not see bus edges either, or it would miss them later
   property p_freeze;
      @(posedge clk) disable iff (reset)
      !clk_en |=> $stable(state_q) && $stable(cnt_q) && $stable(flags_q) && $stable(line_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// *** sim/i2cbc_bus_partner.sv ***
/*
 * Shared two-wire bus beside the condition generator: pull-ups, other
 * parties that may hold either line low, and a foreign clock burst.
 * Assumes the generator's output enables mean "pull the line low".
 */
`default_nettype none
module i2cbc_bus_partner
(
   // generator side
   input  wire logic sda_oe,
   input  wire logic scl_oe,
   // other parties, commanded by the bench
   input  wire logic hold_sda,
   input  wire logic hold_scl,
   input  wire logic frame,
   // resolved lines
   output logic      sda_line,
   output logic      scl_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic link_low = 1'b0;
   // foreign clock runs only inside a frame, still otherwise
   always #62.5 link_low = frame ? ~link_low : 1'b0;
   // wired-and with pull-ups: released lines float high
   assign sda_line = !(sda_oe || hold_sda);
   assign scl_line = !(scl_oe || hold_scl || link_low);
endmodule
`default_nettype wire

// *** sim/tb_i2cbc_core.sv ***
/*
 * Self-checking bench for the condition generator: register access,
 * clean sequences, collisions forced by other bus parties, interrupt.
 * Assumes the Avalon-MM slave answers with waitrequest low.
 */
`default_nettype none
module tb_i2cbc_core
   import i2cbc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        clk_en = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, sda_out, sda_oe, scl_out, scl_oe, irq;
   logic        sda_line, scl_line;
   logic        hold_sda = 1'b0;
   logic        hold_scl = 1'b0;
   logic        frame = 1'b0;
   logic [31:0] q;
   logic [2:0]  cmd [3] = '{3'h1, 3'h2, 3'h4};
   logic [31:0] oe_exp [3] = '{32'h3, 32'h3, 32'h0};
   int          n_errors = 0;
   int          samples_checked = 0;

   always #5 clk = ~clk;

   i2cbc_core i_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_line),
      .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq));

   i2cbc_bus_partner i_bus (.sda_oe(sda_oe), .scl_oe(scl_oe), .hold_sda(hold_sda),
      .hold_scl(hold_scl), .frame(frame), .sda_line(sda_line), .scl_line(scl_line));

   task summarize;
      $display("errors %0d, checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // request held until the edge that samples waitrequest low
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (i == 50)
      begin
         n_errors++;
         summarize();
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      check(q, exp);
   endtask

   task wait_flag(input logic [7:0] m);
      int k;
      for (k = 0; k < 300; k++)
      begin
         bus(1'b0, REG_IRQ_FLAGS, 32'h00000000);
         if ((q[7:0] & m) != 8'h00)
            break;
      end
      if (k == 300)
      begin
         n_errors++;
         summarize();
      end
   endtask

   task start_clean;
      wr(REG_SEQ_CTRL, 32'h00000001);
      wait_flag(8'h08);
      wr(REG_IRQ_FLAGS, 32'h00000028);
   endtask

   // request refused by the bus, then check the abort; holds change gap cycles after the request
   task collide(input logic [2:0] c, input int gap, input logic hs, input logic hc);
      wr(REG_SEQ_CTRL, {29'h0, c});
      repeat (gap) @(posedge clk);
      hold_sda <= hs;
      hold_scl <= hc;
      wait_flag(8'h20);
      rd(REG_IRQ_FLAGS, 32'h00000020);
      check({30'h0, sda_oe, scl_oe}, 32'h0);
      check({30'h0, sda_out, scl_out}, 32'h0);
      rd(REG_SEQ_CTRL, 32'h00000000);
      rd(REG_STATUS, {22'h0, scl_line, sda_line, 8'h00});
   endtask

   // released holder with clock high makes a stop on the bus
   task bus_stop;
      hold_sda <= 1'b0;
      wait_flag(8'h08);
      rd(REG_IRQ_FLAGS, 32'h00000028);
      wr(REG_IRQ_FLAGS, 32'h00000028);
      rd(REG_IRQ_FLAGS, 32'h00000000);
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      rd(REG_BAUD, {24'h0, BAUD_RESET});
      rd(REG_IRQ_FLAGS, 32'h00000000);
      rd(REG_IRQ_ENABLE, 32'h00000000);
      wr(8'hFC, 32'h000000FF);
      rd(8'hFC, 32'h00000000);
      wr(REG_BAUD, 32'h00000004);
      rd(REG_BAUD, 32'h00000004);
      // frozen block misses a stop on the bus
      clk_en <= 1'b0;
      hold_sda <= 1'b1;
      repeat (5) @(posedge clk);
      hold_sda <= 1'b0;
      repeat (5) @(posedge clk);
      clk_en <= 1'b1;
      rd(REG_IRQ_FLAGS, 32'h00000000);
      // start against a data line already low
      hold_sda <= 1'b1;
      collide(3'h1, 0, 1'b1, 1'b0);
      check({31'h0, irq}, 32'h0);
      wr(REG_IRQ_ENABLE, 32'h00000020);
      rd(REG_IRQ_ENABLE, 32'h00000020);
      check({31'h0, irq}, 32'h1);
      wr(REG_IRQ_ENABLE, 32'h00000000);
      rd(REG_IRQ_ENABLE, 32'h00000000);
      check({31'h0, irq}, 32'h0);
      // foreign traffic before the stop that frees the bus
      frame <= 1'b1;
      repeat (100) @(posedge clk);
      frame <= 1'b0;
      repeat (20) @(posedge clk);
      bus_stop();
      // start against a clock line held low
      hold_scl <= 1'b1;
      collide(3'h1, 0, 1'b0, 1'b1);
      hold_scl <= 1'b0;
      wr(REG_IRQ_FLAGS, 32'h00000028);
      // every sequence command, completed cleanly
      for (int c = 0; c < 3; c++)
      begin
         wr(REG_SEQ_CTRL, {29'h0, cmd[c]});
         wait_flag(8'h08);
         rd(REG_IRQ_FLAGS, 32'h00000008);
         check({30'h0, sda_oe, scl_oe}, oe_exp[c]);
         wr(REG_IRQ_FLAGS, 32'h00000028);
      end
      // repeated start with data held low by another master
      start_clean();
      hold_sda <= 1'b1;
      collide(3'h2, 0, 1'b1, 1'b0);
      bus_stop();
      // stop with data held low by another master
      start_clean();
      hold_sda <= 1'b1;
      collide(3'h4, 0, 1'b1, 1'b0);
      bus_stop();
      // slower counts leave room for late interference
      wr(REG_BAUD, {24'h0, BAUD_RESET});
      collide(3'h1, 5, 1'b0, 1'b1);
      hold_scl <= 1'b0;
      wr(REG_IRQ_FLAGS, 32'h00000028);
      // data pulled low by another master inside the first start count
      wr(REG_SEQ_CTRL, 32'h00000001);
      repeat (3) @(posedge clk);
      hold_sda <= 1'b1;
      repeat (6) @(posedge clk);
      check({31'h0, sda_oe}, 32'h00000001);
      wait_flag(8'h08);
      rd(REG_IRQ_FLAGS, 32'h00000008);
      hold_sda <= 1'b0;
      wr(REG_IRQ_FLAGS, 32'h00000028);
      // restart: data falls before the second count ends, no collision
      wr(REG_SEQ_CTRL, 32'h00000002);
      repeat (30) @(posedge clk);
      hold_sda <= 1'b1;
      wait_flag(8'h08);
      rd(REG_IRQ_FLAGS, 32'h00000008);
      hold_sda <= 1'b0;
      wr(REG_IRQ_FLAGS, 32'h00000028);
      // restart: clock pulled low before data is driven
      collide(3'h2, 30, 1'b0, 1'b1);
      hold_scl <= 1'b0;
      wr(REG_IRQ_FLAGS, 32'h00000028);
      // stop: clock pulled low during the count
      start_clean();
      collide(3'h4, 10, 1'b0, 1'b1);
      hold_scl <= 1'b0;
      summarize();
   end
endmodule
`default_nettype wire
